// >>> vme_master_window_decoder_tb.sv
// self-checking bench for the master window decoder
// assumes win_dec answers a host request one cycle later, hreadyout constant
`timescale 1ns/1ps
module vme_master_window_decoder_tb;
  import win_dec_pkg::*;
  logic        hclk, hresetn, soft_rst, hsel, hwrite, hreadyout, hresp, local_hit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  host_req_t   host_req;
  bus_cyc_t    bus_cyc;
  int          bad_count, compares, starts, exp_starts;

  win_dec DUT (.hclk(hclk), .hresetn(hresetn), .soft_rst(soft_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .host_req(host_req), .bus_cyc(bus_cyc), .local_hit(local_hit));
  win_bus_sink sink (.hclk(hclk), .hresetn(hresetn), .bus_cyc(bus_cyc), .starts(starts));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single word transfer; waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  // kind 0 served locally, 1 forwarded with fields, 2 forwarded only
  task automatic host(input logic rm, input logic [31:0] a, input size_t sz,
                      input int kind, input logic [31:0] ea, input logic [5:0] eam);
    @(posedge hclk);
    host_req <= '{valid: 1'b1, real_mode: rm, addr: a, size: sz};
    @(posedge hclk);
    host_req.valid <= 1'b0;
    #1;
    chk({31'h0, local_hit}, (kind == 0) ? 32'h1 : 32'h0);
    chk({31'h0, bus_cyc.start}, (kind == 0) ? 32'h0 : 32'h1);
    if (kind != 0) exp_starts++;
    if (kind == 1)
    begin
      chk(bus_cyc.addr, ea);
      chk({26'h0, bus_cyc.am}, {26'h0, eam});
      chk({30'h0, bus_cyc.size}, {30'h0, sz});
    end
  endtask : host

  // low three modifier bits follow privilege and program/data selects, except A16 (privilege only) and user option clear
  function automatic logic [5:0] am_exp(input logic [31:0] a, input logic [7:0] m);
    logic [2:0] low;
    low = a[27] ? (a[26] ? 3'h6 : 3'h5) : (a[26] ? 3'h2 : 3'h1);
    case (a[29:28])
      2'h3: am_exp = {3'h7, low};
      2'h2: am_exp = {3'h5, a[27] ? 3'h5 : 3'h1};
      2'h1: am_exp = {3'h1, low};
      default: am_exp = m[7] ? {m[5:3], low} : m[5:0];
    endcase
  endfunction : am_exp

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset;
    ahb(1'b0, CMD_OFF, 32'h0); chk(rd, 32'h0);
    ahb(1'b0, MOD_OFF, 32'h0); chk(rd, 32'h0);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF); ahb(1'b0, 8'h20, 32'h0); chk(rd, 32'h0);
    host(1'b1, 32'h000E0000, SZ_BYTE, 0, 32'h0, 6'h0);
    host(1'b0, 32'h7F000000, SZ_LONG, 0, 32'h0, 6'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_real;
    ahb(1'b1, MOD_OFF, 32'h25); ahb(1'b1, SEM_OFF, 32'h80);
    ahb(1'b1, CMD_OFF, 32'h1); ahb(1'b1, PAGE_OFF, 32'hA5C3);
    host(1'b1, 32'h000EABCD, SZ_WORD, 1, 32'hA5C3ABCD, 6'h25);
    host(1'b1, 32'h000EFFFF, SZ_BYTE, 1, 32'hA5C3FFFF, 6'h25);
    host(1'b1, 32'h000F0000, SZ_BYTE, 0, 32'h0, 6'h0);
    host(1'b1, 32'h000DFFFF, SZ_BYTE, 0, 32'h0, 6'h0);
    $display("test real done");
  endtask : test_real

  // all sixteen regions, option clear then set; page low byte is noise
  task automatic test_prot;
    logic [7:0]  m;
    logic [31:0] a;
    for (int o = 0; o < 2; o++)
    begin
      m = o ? 8'hAD : 8'h2D;
      ahb(1'b1, MOD_OFF, {24'h0, m});
      for (int i = 0; i < 16; i++)
      begin
        a = {2'h1, i[3:0], 2'h3, 24'h123457};
        host(1'b0, a, size_t'(i % 3), 1, 32'hA5123456, am_exp(a, m));
      end
    end
    host(1'b0, 32'hC3123456, SZ_LONG, 0, 32'h0, 6'h0);
    host(1'b0, 32'h7E123456, SZ_LONG, 0, 32'h0, 6'h0);
    host(1'b0, 32'h7D123456, SZ_LONG, 0, 32'h0, 6'h0);
    $display("test protected done");
  endtask : test_prot

  task automatic test_mode;
    ahb(1'b1, MODE_OFF, 32'h02);
    host(1'b0, 32'h7F123456, SZ_LONG, 0, 32'h0, 6'h0);
    ahb(1'b1, MODE_OFF, {24'h0, MODE_BIG});
    host(1'b0, 32'h7F123456, SZ_LONG, 1, 32'hA7123456, 6'h3E);
    host(1'b0, 32'h40123456, SZ_LONG, 1, 32'hA0123456, 6'h29);
    host(1'b0, 32'h48123456, SZ_LONG, 0, 32'h0, 6'h0);
    ahb(1'b1, MODE_OFF, {24'h0, MODE_SIXTEEN});
    $display("test mode done");
  endtask : test_mode

  task automatic test_soft;
    @(posedge hclk) soft_rst <= 1'b1;
    @(posedge hclk) soft_rst <= 1'b0;
    ahb(1'b0, CMD_OFF, 32'h0); chk(rd, 32'h1);
    ahb(1'b0, MOD_OFF, 32'h0); chk(rd, 32'h0);
    host(1'b1, 32'h000E0010, SZ_LONG, 1, 32'hA5C30010, 6'h00);
    @(posedge hclk) #1 chk(starts, exp_starts);
    $display("test soft reset done");
  endtask : test_soft

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------------
  always #5 hclk = ~hclk;

  initial
  begin
    hclk = 0; hresetn = 0; soft_rst = 0; hsel = 0; haddr = 0; htrans = 0;
    hwrite = 0; hsize = 0; hwdata = 0; host_req = '0;
    bad_count = 0; compares = 0; exp_starts = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset;
    test_real;
    test_prot;
    test_mode;
    test_soft;
    print_verdict;
  end

  // the run needs well under 1000 cycles; this cuts a hang short
  initial
  begin
    #100000;
    bad_count++;
    print_verdict;
  end
endmodule : vme_master_window_decoder_tb

// >>> win_bus_sink.sv
// far side model: counts master cycles issued by the window decoder
// assumes bus_cyc is a registered one-cycle start pulse on hclk
`timescale 1ns/1ps
module win_bus_sink
(
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // master cycle from the decoder
  input  wire win_dec_pkg::bus_cyc_t bus_cyc,
  // observation
  output int                         starts
);
  import win_dec_pkg::*;

  // takes every cycle at once; a slow slave only stretches the far bus,
  // which the decoder never sees, so no stall is modelled here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      starts <= 0;
    else if (bus_cyc.start)
      starts <= starts + 1;
  end
endmodule : win_bus_sink

// >>> win_dec.sv
// master window decoder: host accesses to bus master cycles, AHB-Lite regs
// assumes host requests arrive on hclk; soft_rst is a synchronous pulse
//
// Notes on behaviour
// - real mode window E0000-EFFFF forwards only while bus enable is set
// - real mode modifier comes from modifier register bits 5-0
// - real mode: A31-A16 from page register, A15-A0 from host
// - byte, word and longword accesses keep their size on the bus
// - protected hit needs A31=0, A30=1, A25=1, A24=1
// - protected mode: A31-A24 from page register, A23-A1 from host
// - host A29-A26 pick one of sixteen regions, same bus address
// - A29:A28 pick A24, A16, A32 or user-defined space
// - A27 supervisory or not, A26 program or data
// - user region: option clear gives bits 5-0, set gives 5-3 plus 6,5,2,1
// - modifier option bit resets to zero
// - outside real mode, modifier register used only when A29 and A28 are both zero
// - protected mode ignores page register bits 7-0
// - sixteen-region decoding only while mode port holds zero
// - 128 Mbyte mode from 4000_0000 with user and automatic modifiers
// - 128 Mbyte mode: A31-A27 from page register, A26-A0 from host
// - bus enable clears at reset, survives a soft reset
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module win_dec
(
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   soft_rst,
  // register bus
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // host access port
  input  wire win_dec_pkg::host_req_t host_req,
  // bus master cycle and local service
  output win_dec_pkg::bus_cyc_t       bus_cyc,
  output logic                        local_hit
);
  import win_dec_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic        bus_en_reg;
  logic [7:0]  mod_reg;
  logic [15:0] page_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  sem_reg;
  logic [1:0]  stat_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_off_reg;
  bus_cyc_t    cyc_reg;
  logic        local_reg;

  // automatic modifier: space and privilege/program bits to a code
  function automatic logic [5:0] auto_am(input logic [1:0] asz, input logic sup,
                                         input logic pgm);
    logic [5:0] base;
    base = 6'h00;
    unique case (asz)
      AS_A24:  base = 6'h38;
      AS_A16:  base = 6'h28;
      AS_A32:  base = 6'h08;
      AS_USER: base = 6'h00;
    endcase
    // short space has no program/data split: supervisory sets bit 2, low bits fixed
    if (asz == AS_A16)
      auto_am = base | {3'b000, sup, 2'b01};
    else
      auto_am = base | {3'b000, sup, pgm, ~pgm};
  endfunction : auto_am

  // user-defined modifier with optional low-bit override
  function automatic logic [5:0] user_am(input logic [7:0] m, input logic sup,
                                         input logic pgm);
    logic [2:0] low;
    // 11 -> 6, 10 -> 5, 01 -> 2, 00 -> 1
    low = {sup, pgm, ~pgm};
    if (m[OPT_BIT])
      user_am = {m[5:3], low};
    else
      user_am = m[5:0];
  endfunction : user_am

  // ----------------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------------
  wire [31:0] a         = host_req.addr;
  wire [1:0]  asz       = a[29:28];
  wire        sup       = a[27];
  wire        pgm       = a[26];
  wire        real_hit  = host_req.real_mode && a[31:20] == 12'h000 &&
                          a[19:0] >= REAL_BASE && a[19:0] <= REAL_LAST;
  wire        prot16_hit = !host_req.real_mode && mode_reg == MODE_SIXTEEN &&
                           !a[31] && a[30] && a[25] && a[24];
  wire        prot128_hit = !host_req.real_mode && mode_reg == MODE_BIG &&
                            !a[31] && a[30] &&
                            (asz != AS_USER || !a[27]);
  wire        any_hit   = real_hit || prot16_hit || prot128_hit;
  wire        go        = host_req.valid && any_hit && bus_en_reg;
  // a16 in the big mode has no program bit, so pgm is ignored there
  wire [5:0]  prot_am   = (asz == AS_USER) ? user_am(mod_reg, sup, pgm)
                                           : auto_am(asz, sup, pgm);
  wire [5:0]  am_sel    = real_hit ? mod_reg[5:0] : prot_am;
  wire [31:0] addr_sel  = real_hit    ? {page_reg, a[15:0]}
                        : prot16_hit  ? {page_reg[15:8], a[23:1], 1'b0}
                        :               {page_reg[15:11], a[26:0]};

  // bus cycle register, one pulse per forwarded host request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_reg   <= '0;
      local_reg <= 1'b0;
    end
    else
    begin
      cyc_reg.start <= go;
      local_reg     <= host_req.valid && !go;
      if (go)
      begin
        cyc_reg.addr <= addr_sel;
        cyc_reg.am   <= am_sel;
        cyc_reg.size <= host_req.size;
      end
    end
  end

  assign bus_cyc   = cyc_reg;
  assign local_hit = local_reg;

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  wire       ahb_take = hsel && hready && htrans[1];
  wire [7:0] rd_off   = haddr[7:0];
  wire [31:0] rd_word = (rd_off == CMD_OFF)  ? {31'h0, bus_en_reg}
                      : (rd_off == MOD_OFF)  ? {24'h0, mod_reg}
                      : (rd_off == PAGE_OFF) ? {16'h0, page_reg}
                      : (rd_off == MODE_OFF) ? {24'h0, mode_reg}
                      : (rd_off == SEM_OFF)  ? {24'h0, sem_reg}
                      : (rd_off == STAT_OFF) ? {30'h0, stat_reg}
                      :                        32'h0000_0000;

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_off_reg  <= 8'h00;
      hrdata      <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= ahb_take && hwrite;
      wr_off_reg  <= rd_off;
      if (ahb_take && !hwrite)
        hrdata <= rd_word;
    end
  end

  // config registers; bus enable keeps its value over soft reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_en_reg <= 1'b0;
      mod_reg    <= MOD_RST;
      page_reg   <= PAGE_RST;
      mode_reg   <= MODE_RST;
      sem_reg    <= 8'h00;
      stat_reg   <= 2'b00;
    end
    else
    begin
      if (soft_rst)
      begin
        mod_reg  <= MOD_RST;
        mode_reg <= MODE_RST;
      end
      else if (wr_pend_reg)
      begin
        unique case (wr_off_reg)
          CMD_OFF:  bus_en_reg <= hwdata[BUS_EN_BIT];
          MOD_OFF:  mod_reg    <= hwdata[7:0];
          PAGE_OFF: page_reg   <= hwdata[15:0];
          MODE_OFF: mode_reg   <= hwdata[7:0];
          SEM_OFF:  sem_reg    <= hwdata[7:0];
          default:  ;
        endcase
      end
      if (host_req.valid)
        stat_reg <= {go, any_hit};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  real_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    host_req.valid && real_hit && !bus_en_reg |=> !bus_cyc.start)
    else $error("real window access started while disabled");
  real_am_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go && real_hit |=> bus_cyc.am == $past(mod_reg[5:0]))
    else $error("real mode modifier mismatch");
  real_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go && real_hit |=> bus_cyc.addr == {$past(page_reg), $past(a[15:0])})
    else $error("real mode address mismatch");
  size_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go |=> bus_cyc.size == $past(host_req.size))
    else $error("access size not kept");
  prot_hit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    host_req.valid && !host_req.real_mode && mode_reg == MODE_SIXTEEN &&
    !(a[30] && a[25] && a[24] && !a[31]) |=> !bus_cyc.start)
    else $error("protected miss started a cycle");
  prot_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go && prot16_hit |=> bus_cyc.addr[31:24] == $past(page_reg[15:8]) &&
    bus_cyc.addr[23:1] == $past(a[23:1]))
    else $error("protected address mismatch");
  a24_sup_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go && prot16_hit && asz == AS_A24 && sup && pgm |=> bus_cyc.am == 6'h3E)
    else $error("a24 supervisory program modifier wrong");
  user_opt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go && prot16_hit && asz == AS_USER && mod_reg[OPT_BIT] && sup && !pgm
    |=> bus_cyc.am == {$past(mod_reg[5:3]), 3'd5})
    else $error("user option low bits wrong");
  miss_local_a: assert property (@(posedge hclk) disable iff (!hresetn)
    host_req.valid && !go |=> local_hit && !bus_cyc.start)
    else $error("miss not served locally");

endmodule : win_dec

// >>> win_dec_pkg.sv
// package for the master window decoder: register map, fields, reset values
// assumes a single AHB-Lite master and a 32-bit host address request port
package win_dec_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_OFF   = 8'h00;  // general command (bus enable)
  localparam logic [7:0] MOD_OFF   = 8'h04;  // user modifier select
  localparam logic [7:0] PAGE_OFF  = 8'h08;  // upper address page
  localparam logic [7:0] MODE_OFF  = 8'h0C;  // window mode port
  localparam logic [7:0] SEM_OFF   = 8'h10;  // mailbox semaphore
  localparam logic [7:0] STAT_OFF  = 8'h14;  // last decode status

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         BUS_EN_BIT    = 0;
  localparam int         OPT_BIT       = 7;
  localparam int         SYSFAIL_BIT   = 7;
  localparam logic [7:0] MOD_RST       = 8'h00;
  localparam logic [15:0] PAGE_RST     = 16'h0000;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [7:0] MODE_SIXTEEN  = 8'h00;
  localparam logic [7:0] MODE_BIG      = 8'h01;

  // ----------------------------------------------------------------------
  // window bounds
  // ----------------------------------------------------------------------
  localparam logic [19:0] REAL_BASE    = 20'hE0000;
  localparam logic [19:0] REAL_LAST    = 20'hEFFFF;
  localparam logic [1:0]  AS_A24       = 2'b11;
  localparam logic [1:0]  AS_A16       = 2'b10;
  localparam logic [1:0]  AS_A32       = 2'b01;
  localparam logic [1:0]  AS_USER      = 2'b00;

  // ----------------------------------------------------------------------
  // host request and bus cycle carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } size_t;

  typedef struct packed
  {
    logic        valid;
    logic        real_mode;
    logic [31:0] addr;
    size_t       size;
  } host_req_t;

  typedef struct packed
  {
    logic        start;
    logic [31:0] addr;
    logic [5:0]  am;
    size_t       size;
  } bus_cyc_t;

endpackage : win_dec_pkg
